/* File: logic/dcm_pkg.sv */
// Register map, reset values and carriers of the display chroma/matrix/OSD/frame/SVM block
package dcm_pkg;
   // Sub-address offsets
   localparam logic [7:0] A_OSD_COLOUR_TABLE_LO = 8'h00;
   localparam logic [7:0] A_OSD_COLOUR_TABLE_HI = 8'h0f;
   localparam logic [7:0] A_FCOL    = 8'h11;
   localparam logic [7:0] A_CIF     = 8'h14;
   localparam logic [7:0] A_TRC     = 8'h66;
   localparam logic [7:0] A_CTB     = 8'h44;
   localparam logic [7:0] A_CTG     = 8'h48;
   localparam logic [7:0] A_CTR     = 8'h4c;
   localparam logic [7:0] A_FHB     = 8'h4f;
   localparam logic [7:0] A_FHE     = 8'h53;
   localparam logic [7:0] A_FVB     = 8'h63;
   localparam logic [7:0] A_FVE     = 8'h6f;
   localparam logic [7:0] A_MR1     = 8'h7c;
   localparam logic [7:0] A_MR2     = 8'h74;
   localparam logic [7:0] A_MG1     = 8'h6c;
   localparam logic [7:0] A_MG2     = 8'h64;
   localparam logic [7:0] A_MB1     = 8'h5c;
   localparam logic [7:0] A_MB2     = 8'h54;
   localparam logic [7:0] A_SR1     = 8'h78;
   localparam logic [7:0] A_SR2     = 8'h70;
   localparam logic [7:0] A_SG1     = 8'h68;
   localparam logic [7:0] A_SG2     = 8'h60;
   localparam logic [7:0] A_SB1     = 8'h58;
   localparam logic [7:0] A_SB2     = 8'h50;
   localparam logic [7:0] A_SVV     = 8'h62;
   localparam logic [7:0] A_SVT     = 8'h5e;
   localparam logic [7:0] A_SVL     = 8'h5a;
   localparam logic [7:0] A_SVD     = 8'h56;
   localparam logic [7:0] A_MSIDE   = 8'h75;
   localparam logic [7:0] A_MEXT    = 8'h71;
   localparam logic [7:0] A_FID     = 8'h47;
   // Indices into the 9-bit setting bank
   localparam int I_TRC = 0;
   localparam int I_CTR = 3;
   localparam int I_FHB = 4;
   localparam int I_FHE = 5;
   localparam int I_FVB = 6;
   localparam int I_FVE = 7;
   localparam int I_MC  = 8;
   localparam int I_SC  = 14;
   localparam int I_SB2 = 19;
   localparam int I_SVV = 20;
   localparam int I_SVT = 21;
   localparam int I_SVL = 22;
   localparam int I_SVD = 23;
   localparam int I_MSIDE = 24;
   localparam int I_MEXT  = 25;
   localparam int I_FID   = 26;
   localparam int NCFG    = 27;
   localparam logic [7:0] CFG_ADDR [NCFG] = '{
      A_TRC, A_CTB, A_CTG, A_CTR, A_FHB, A_FHE, A_FVB, A_FVE,
      A_MR1, A_MR2, A_MG1, A_MG2, A_MB1, A_MB2,
      A_SR1, A_SR2, A_SG1, A_SG2, A_SB1, A_SB2,
      A_SVV, A_SVT, A_SVL, A_SVD, A_MSIDE, A_MEXT, A_FID};
   localparam logic [8:0] CFG_RST [NCFG] = '{
      9'h151, 9'h088, 9'h088, 9'h088, 9'h000, 9'h000, 9'h10e, 9'h038,
      9'h000, 9'h056, 9'h1ea, 9'h1d4, 9'h071, 9'h000,
      9'h000, 9'h049, 9'h1ed, 9'h1db, 9'h061, 9'h000,
      9'h13c, 9'h13c, 9'h064, 9'h007, 9'h000, 9'h000, 9'h000};
   localparam logic [7:0]  CIF_RST  = 8'h08;
   localparam logic [11:0] FCOL_RST = 12'h000;
   // Power-up colour table
   localparam logic [11:0] OSD_COLOUR_TABLE_RST [16] = '{
      12'h000, 12'hf00, 12'h0f0, 12'h0f0, 12'h00f, 12'hf0f, 12'h0ff, 12'h7ff,
      12'h777, 12'h700, 12'h070, 12'h007, 12'h770, 12'h707, 12'h077, 12'hfff};
   // Field positions
   localparam int F_POL   = 3;
   localparam int F_ORDER = 4;
   localparam int F_BW    = 8;
   localparam int F_FEN   = 8;
   localparam int LUMA_DLY = 3;

   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] chroma;
      logic       chroma_first;
      logic [2:0] prio;
      logic [3:0] osd_idx;
      logic [8:0] hpos;
      logic [8:0] vline;
      logic       field_start;
   } dcm_pix_s;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } dcm_rgb_s;

   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] data;
   } dcm_regwr_s;
endpackage

/* File: logic/dcm_top.sv */
// Chroma formatting, inverse matrix, OSD table, frame generator and scan velocity modulation
// Summary of operation
// - Chroma delayed versus luma by -3..+4 steps from three-bit delay field.
// - Chroma samples read as two's complement or offset binary by polarity bit.
// - First multiplexed chroma sample is blue or red difference per order bit.
// - Transient stage applies 4-bit coring, 4-bit gain, narrow or wide bandwidth.
// - Main colour difference is coef one times Cb plus coef two times Cr, /128.
// - Independent side coefficient set of same format used for side pixels.
// - OSD table has 16 entries of 12 bits: blue low, green middle, red top.
// - Table entries take fixed default colours at power-up without host writes.
// - Frame colour is a 12-bit value packed like a table entry.
// - OSD amplitude per colour is table level times (OSD contrast + 4).
// - Frame amplitude per colour is frame level times (upper contrast nibble + 4).
// - Horizontal begin 0 disables frame; 1FF makes frame cover the full width of each frame line.
// - Vertical begin 0 disables frame; otherwise it is the first frame line.
// - Frame ends at 9-bit horizontal end position and vertical end line.
// - Video mode modulation uses 6-bit gain, 3-bit differentiator delay, 0 off.
// - Text mode modulation uses its own gain and delay of the same format.
// - Modulation clipped to 7-bit limit; host writes zeros to upper limit bits.
// - Modulation output delay field in half clock steps, used as whole clocks; setting 5 lags colour output by 3 clocks.
// - 4-bit coring applied to modulation; host writes zero to unused top bit.
// - Per pixel, priority mask bit picks main or side matrix.
// - Per pixel, priority mask bit picks video colour or table colour.
// - Frame priority id is used only when its enable bit is set.
`timescale 1ns/10ps
module dcm_top
   import dcm_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire dcm_pkg::dcm_pix_s   pix_i,
   input  wire dcm_pkg::dcm_regwr_s reg_wr,
   input  wire logic [7:0]       reg_raddr,
   output dcm_pkg::dcm_rgb_s     colour_output,
   output logic signed [7:0]     velmod_output,
   output logic [15:0]           reg_rdata
);
   import dcm_pkg::*;

   // Saturate a signed sum to 0..255
   function automatic logic [7:0] sat_u8(input logic signed [19:0] v);
      if (v < 20'sd0) begin
         sat_u8 = 8'h00;
      end else if (v > 20'sd255) begin
         sat_u8 = 8'hff;
      end else begin
         sat_u8 = v[7:0];
      end
   endfunction

   // Insertion amplitude, level times (contrast + 4)
   function automatic logic [7:0] ins_amp(input logic [3:0] lvl, input logic [3:0] ct);
      logic [9:0] p;
      p = 10'(lvl) * (10'(ct) + 10'd4);
      ins_amp = (p > 10'd255) ? 8'hff : p[7:0];
   endfunction

   // Transient improvement on one colour-difference component
   function automatic logic signed [7:0] dti_f(
      input logic signed [7:0] cur,
      input logic signed [7:0] rf,
      input logic signed [7:0] mid,
      input logic [3:0] cor,
      input logic [3:0] gain);
      logic signed [8:0]  d;
      logic signed [8:0]  ad;
      logic signed [13:0] b;
      logic signed [15:0] s;
      d = $signed({cur[7], cur}) - $signed({rf[7], rf});
      ad = (d < 9'sd0) ? -d : d;
      if (ad <= $signed({5'h0, cor})) begin
         d = 9'sd0;
      end
      b = d * $signed({1'b0, gain});
      s = $signed({{8{mid[7]}}, mid}) + 16'(b >>> 3);
      if (s > 16'sd127) begin
         dti_f = 8'sd127;
      end else if (s < -16'sd128) begin
         dti_f = -8'sd128;
      end else begin
         dti_f = s[7:0];
      end
   endfunction

   // Setting bank, write-only 9-bit registers and their active copies, field-aligned for frame and coefficients
   logic [8:0]  cfg_q [NCFG];
   logic [8:0]  act_q [NCFG];
   logic [7:0]  cif_q;
   logic [11:0] fcol_q;
   logic [11:0] fcol_act_q;
   logic [11:0] osd_colour_table_q [16];
   wire         fld = pix_i.field_start;

   genvar gi;
   generate
      for (gi = 0; gi < NCFG; gi++) begin : g_cfg
         wire hit = reg_wr.wr && (reg_wr.addr == CFG_ADDR[gi]);
         wire hold = (gi >= I_FHB) && (gi <= I_SB2);
         // Host write to the setting
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               cfg_q[gi] <= CFG_RST[gi];
            end else if (hit) begin
               cfg_q[gi] <= reg_wr.data[8:0];
            end
         end
         // Frame and coefficient copies wait for a new field
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               act_q[gi] <= CFG_RST[gi];
            end else if (!hold || fld) begin
               act_q[gi] <= cfg_q[gi];
            end
         end
      end
   endgenerate

   // Format, frame colour and colour table writes
   wire cif_we  = reg_wr.wr && (reg_wr.addr == A_CIF);
   wire fcol_we = reg_wr.wr && (reg_wr.addr == A_FCOL);
   wire osd_colour_table_we = reg_wr.wr && (reg_wr.addr <= A_OSD_COLOUR_TABLE_HI);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cif_q      <= CIF_RST;
         fcol_q     <= FCOL_RST;
         fcol_act_q <= FCOL_RST;
      end else begin
         if (cif_we) begin
            cif_q <= reg_wr.data[7:0]; // test bit kept only for read
         end
         if (fcol_we) begin
            fcol_q <= reg_wr.data[11:0];
         end
         if (fld) begin
            fcol_act_q <= fcol_q;
         end
      end
   end

   // Colour table with power-up contents
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            osd_colour_table_q[i] <= OSD_COLOUR_TABLE_RST[i];
         end
      end else if (osd_colour_table_we) begin
         osd_colour_table_q[reg_wr.addr[3:0]] <= reg_wr.data[11:0];
      end
   end

   // Read-back of the only readable register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= (reg_raddr == A_CIF) ? {8'h00, cif_q} : 16'h0000;
      end
   end

   // Chroma input formatting
   wire [7:0] c_fmt = cif_q[F_POL] ? {~pix_i.chroma[7], pix_i.chroma[6:0]}
                                   : pix_i.chroma;
   logic [7:0] first_q;
   logic [7:0] cb_q;
   logic [7:0] cr_q;
   wire        ord = cif_q[F_ORDER];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         first_q <= 8'h00;
         cb_q    <= 8'h00;
         cr_q    <= 8'h00;
      end else if (pix_i.chroma_first) begin
         first_q <= c_fmt;
      end else begin
         cb_q <= ord ? c_fmt : first_q;
         cr_q <= ord ? first_q : c_fmt;
      end
   end

   // Chroma and pixel delay lines; luma sits at the middle tap
   logic [7:0][15:0] cc_hist_q;
   dcm_pix_s [LUMA_DLY:0] p_hist_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cc_hist_q <= '0;
         p_hist_q  <= '0;
      end else begin
         cc_hist_q <= {cc_hist_q[6:0], cb_q, cr_q};
         p_hist_q  <= {p_hist_q[LUMA_DLY-1:0], pix_i};
      end
   end

   // Tap 3 plus delay field, wrapping modulo 8, 0..7
   wire [2:0]  c_tap = 3'(3'd3 + cif_q[2:0]);
   wire [15:0] c_sel = cc_hist_q[c_tap];
   wire dcm_pix_s p_al = p_hist_q[LUMA_DLY];

   // Transient improvement per component
   logic [1:0][7:0] t0_q;
   logic [1:0][7:0] t1_q;
   logic [1:0][7:0] t2_q;
   logic [1:0][7:0] dti_q;
   dcm_pix_s   p_dti_q;
   wire [3:0] tr_cor  = act_q[I_TRC][3:0];
   wire [3:0] tr_gain = act_q[I_TRC][7:4];
   wire       tr_wide = act_q[I_TRC][F_BW];

   generate
      for (gi = 0; gi < 2; gi++) begin : g_dti
         wire signed [7:0] rf = tr_wide ? $signed(t1_q[gi]) : $signed(t2_q[gi]);
         // Component history and boosted edge
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               t0_q[gi]  <= 8'h00;
               t1_q[gi]  <= 8'h00;
               t2_q[gi]  <= 8'h00;
               dti_q[gi] <= 8'h00;
            end else begin
               t0_q[gi]  <= c_sel[8*gi +: 8];
               t1_q[gi]  <= t0_q[gi];
               t2_q[gi]  <= t1_q[gi];
               dti_q[gi] <= dti_f($signed(t0_q[gi]), rf, $signed(t1_q[gi]),
                                  tr_cor, tr_gain);
            end
         end
      end
   endgenerate

   // Pixel attributes follow the transient stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         p_dti_q <= '0;
      end else begin
         p_dti_q <= p_al;
      end
   end

   // Priority masks and frame window
   wire [2:0] pr       = p_dti_q.prio;
   wire       use_side = act_q[I_MSIDE][pr];
   wire       use_ext  = act_q[I_MEXT][pr];
   wire [8:0] hb = act_q[I_FHB];
   wire [8:0] he = act_q[I_FHE];
   wire [8:0] vb = act_q[I_FVB];
   wire [8:0] ve = act_q[I_FVE];
   wire [8:0] hp = p_dti_q.hpos;
   wire [8:0] vl = p_dti_q.vline;
   wire h_full = (hb == 9'h1ff);
   wire h_in   = (hb != 9'h000) && (h_full || ((hp >= hb) && (hp <= he)));
   wire v_in   = (vb != 9'h000) && (vl >= vb) && (vl <= ve);
   wire f_en   = act_q[I_FID][F_FEN];
   wire f_pri  = !f_en || (pr <= act_q[I_FID][2:0]);
   wire in_frm = h_in && v_in && f_pri;
   wire signed [7:0] cbv = $signed(dti_q[1]);
   wire signed [7:0] crv = $signed(dti_q[0]);
   wire [11:0] osd_e = osd_colour_table_q[p_dti_q.osd_idx];

   // Per colour: matrix, insertion amplitudes and output choice
   logic [2:0][7:0] col_d;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_col
         wire [8:0] c1 = use_side ? act_q[I_SC + 2*gi] : act_q[I_MC + 2*gi];
         wire [8:0] c2 = use_side ? act_q[I_SC + 2*gi + 1] : act_q[I_MC + 2*gi + 1];
         wire signed [17:0] mx = $signed(c1) * cbv + $signed(c2) * crv;
         wire signed [19:0] sum = $signed({12'h000, p_dti_q.luma}) + 20'(mx >>> 7);
         wire [7:0] vid = sat_u8(sum);
         wire [3:0] ct  = act_q[I_CTR - gi][3:0];
         wire [3:0] fct = act_q[I_CTR - gi][7:4];
         wire [7:0] osd = ins_amp(osd_e[4*(2-gi) +: 4], ct);
         wire [7:0] frm = ins_amp(fcol_act_q[4*(2-gi) +: 4], fct);
         assign col_d[gi] = in_frm ? frm : (use_ext ? osd : vid);
      end
   endgenerate

   // Colour output register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         colour_output <= '0;
      end else begin
         colour_output <= '{r: col_d[0], g: col_d[1], b: col_d[2]};
      end
   end

   // Scan velocity modulation: text mode on table-coloured pixels
   logic [7:0][7:0] y_hist_q;
   wire [8:0] sv_set = use_ext ? act_q[I_SVT] : act_q[I_SVV];
   wire [5:0] sv_gain = sv_set[5:0];
   wire [2:0] sv_dly  = sv_set[8:6];
   wire [6:0] sv_lim  = act_q[I_SVL][6:0];
   wire [3:0] sv_cor  = act_q[I_SVD][7:4];
   wire [2:0] sv_out  = 3'(act_q[I_SVD][3:0] >> 1);
   wire signed [8:0] y_d = $signed({1'b0, p_dti_q.luma})
                         - $signed({1'b0, y_hist_q[sv_dly]});
   wire signed [8:0] y_df = (sv_dly == 3'd0) ? 9'sd0 : y_d;
   wire signed [15:0] sv_p = y_df * $signed({1'b0, sv_gain});
   wire signed [15:0] sv_s = sv_p >>> 4;
   wire signed [15:0] sv_a = (sv_s < 16'sd0) ? -sv_s : sv_s;
   wire signed [15:0] sv_c = (sv_a <= $signed({12'h000, sv_cor})) ? 16'sd0 : sv_s;
   wire signed [15:0] lim  = $signed({9'h000, sv_lim});
   wire signed [15:0] sv_l = (sv_c > lim) ? lim : ((sv_c < -lim) ? -lim : sv_c);
   logic [7:0][7:0] sv_hist_q;

   // Differentiator history and whole-clock output delay
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         y_hist_q  <= '0;
         sv_hist_q <= '0;
      end else begin
         y_hist_q  <= {y_hist_q[6:0], p_dti_q.luma};
         sv_hist_q <= {sv_hist_q[6:0], sv_l[7:0]};
      end
   end

   // Modulation output register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         velmod_output <= 8'sd0;
      end else begin
         velmod_output <= $signed(sv_hist_q[sv_out]);
      end
   end
endmodule

/* File: testbench/dcm_top_props.sv */
// Port-level assertions for the display datapath block
`timescale 1ns/10ps
module dcm_top_props (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire dcm_pkg::dcm_pix_s   pix_i,
   input wire dcm_pkg::dcm_regwr_s reg_wr,
   input wire logic [7:0]          reg_raddr,
   input wire dcm_pkg::dcm_rgb_s   colour_output,
   input wire logic signed [7:0]   velmod_output,
   input wire logic [15:0]         reg_rdata
);
   import dcm_pkg::*;
   logic [1:0] up_q;
   logic [5:0] flat_q;
   logic [7:0] luma_q;
   logic       fmt_seen_q;
   wire        fmt_wr = reg_wr.wr && reg_wr.addr == A_CIF;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Edges since reset, run of steady luma, format write seen
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_q <= 2'h0;
         flat_q <= 6'h00;
         luma_q <= 8'h00;
         fmt_seen_q <= 1'b0;
      end else begin
         up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
         flat_q <= (pix_i.luma != luma_q) ? 6'h00 : (flat_q == 6'h3f) ? flat_q : flat_q + 6'h01;
         luma_q <= pix_i.luma;
         fmt_seen_q <= fmt_seen_q | fmt_wr;
      end
   end

   // Format write followed by a read of the same place
   sequence s_fmt_write;
      fmt_wr ##1 (reg_raddr == A_CIF && !reg_wr.wr);
   endsequence

   a_unmapped_read_zero: assert property (reg_raddr != A_CIF |=> reg_rdata == 16'h0000)
      else $error("read data not zero for an unreadable address");
   a_format_upper_zero: assert property (reg_raddr == A_CIF |=> reg_rdata[15:8] == 8'h00)
      else $error("upper read byte not zero");
   a_format_write_back: assert property (s_fmt_write |=> reg_rdata[7:0] == $past(reg_wr.data[7:0], 2))
      else $error("format register did not return written value");
   a_format_hold: assert property (up_q == 2'h3 && reg_raddr == A_CIF && $past(reg_raddr) == A_CIF
      && !$past(reg_wr.wr) |=> reg_rdata == $past(reg_rdata))
      else $error("format register changed without a write");
   a_format_default: assert property (!fmt_seen_q && reg_raddr == A_CIF |=> reg_rdata == {8'h00, CIF_RST})
      else $error("format register default wrong");
   a_reset_quiet: assert property (disable iff (1'b0) rst |-> colour_output == 24'h000000
      && velmod_output == 8'sh00 && reg_rdata == 16'h0000)
      else $error("outputs not cleared during reset");
   a_velmod_clip: assert property (velmod_output != 8'sh80)
      else $error("modulation output beyond seven-bit limit");
   a_velmod_flat: assert property (flat_q == 6'h3f |-> velmod_output == 8'sh00)
      else $error("modulation output not zero on flat luma");
endmodule

bind dcm_top dcm_top_props dcm_top_props_i (.ref_clk(ref_clk), .rst(rst), .pix_i(pix_i),
   .reg_wr(reg_wr), .reg_raddr(reg_raddr), .colour_output(colour_output),
   .velmod_output(velmod_output), .reg_rdata(reg_rdata));

/* File: testbench/dcm_pix_src.sv */
// Upstream pixel source: steady pixels in a small raster with field pulse
`timescale 1ns/10ps
module dcm_pix_src (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  luma,
   input  wire logic [7:0]  first_c,
   input  wire logic [7:0]  second_c,
   input  wire logic [2:0]  prio,
   input  wire logic [3:0]  idx,
   output dcm_pkg::dcm_pix_s pix_o
);
   import dcm_pkg::*;
   logic [4:0] h_q;
   logic [2:0] v_q;
   wire  [7:0] chroma = h_q[0] ? second_c : first_c;
   wire        fld = h_q == 5'h00 && v_q == 3'h1;

   // Raster of four lines of 32 pixels, updated just after the edge
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         h_q <= 5'h00;
         v_q <= 3'h1;
      end else begin
         h_q <= #1 h_q + 5'h01;
         if (h_q == 5'h1f) begin
            v_q <= #1 (v_q == 3'h4) ? 3'h1 : v_q + 3'h1;
         end
      end
   end

   // Chroma pairs start on even pixels, luma as the bench sets it
   assign pix_o = {luma, chroma, ~h_q[0], prio, idx, {4'h0, h_q}, {6'h00, v_q}, fld};
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the display datapath block
`timescale 1ns/10ps
module tb;
   import dcm_pkg::*;
   localparam logic [23:0] OSD5 = 24'h99cc0c;
   localparam logic [23:0] FRM  = 24'h0c1824;
   logic              ref_clk;
   logic              rst;
   dcm_regwr_s        reg_wr;
   logic [7:0]        reg_raddr;
   logic [7:0]        luma;
   logic [7:0]        fc;
   logic [7:0]        sc;
   logic [2:0]        prio;
   logic [3:0]        idx;
   dcm_pix_s          pix;
   dcm_rgb_s          rgb;
   logic signed [7:0] vm;
   logic [15:0]       rdata;
   int                n_mismatch;
   int                n_checks;

   dcm_pix_src dcm_pix_src_i (.ref_clk(ref_clk), .rst(rst), .luma(luma), .first_c(fc),
      .second_c(sc),
      .prio(prio), .idx(idx), .pix_o(pix));
   dcm_top dcm_top_i (.ref_clk(ref_clk), .rst(rst), .pix_i(pix), .reg_wr(reg_wr),
      .reg_raddr(reg_raddr), .colour_output(rgb), .velmod_output(vm), .reg_rdata(rdata));

   // Clock at 40 MHz
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_wr = '{1'b1, a, d};
      tick;
      reg_wr.wr = 1'b0;
      tick;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_raddr = a;
      tick;
      chk({8'h00, rdata}, {8'h00, e});
   endtask

   // Optional wait for a field start, then let the pipeline settle
   task automatic settle(input bit fld);
      int k;
      k = 0;
      while (fld && pix.field_start !== 1'b1 && k < 300) begin
         tick;
         k++;
      end
      if (k == 300) begin
         n_mismatch++;
         complete_run;
      end else begin
         repeat (20) tick;
      end
   endtask

   function automatic logic [7:0] amp(input logic [3:0] n, input logic [3:0] c);
      return 8'(n) * (8'(c) + 8'h04);
   endfunction

   task automatic t_format;
      rd(A_CIF, {8'h00, CIF_RST});
      wr(A_CIF, 16'h0013);
      rd(A_CIF, 16'h0013);
      rd(8'h15, 16'h0000);
      wr(A_CIF, {8'h00, CIF_RST});
   endtask

   task automatic t_table;
      logic [11:0] e;
      wr(A_MEXT, 16'h00ff);
      for (int i = 0; i < 16; i++) begin
         idx = 4'(i);
         e = OSD_COLOUR_TABLE_RST[i];
         settle(1'b0);
         chk(rgb, {amp(e[11:8], 4'h8), amp(e[7:4], 4'h8), amp(e[3:0], 4'h8)});
      end
      wr(A_OSD_COLOUR_TABLE_LO + 8'h05, 16'h09c3);
      wr(A_CTB, 16'h0080);
      wr(A_CTG, 16'h008d);
      wr(A_CTR, 16'h008d);
      idx = 4'h5;
      settle(1'b0);
      chk(rgb, OSD5);
      idx = 4'h4;
      settle(1'b0);
      chk(rgb, 24'h00003c);
      idx = 4'h5;
   endtask

   task automatic t_frame;
      settle(1'b1);
      wr(A_FCOL, 16'h0123);
      wr(A_FVB, 16'h0001);
      wr(A_FVE, 16'h01ff);
      wr(A_FHB, 16'h01ff);
      chk(rgb, OSD5);
      settle(1'b1);
      chk(rgb, FRM);
      prio = 3'h5;
      wr(A_FID, 16'h0103);
      settle(1'b1);
      chk(rgb, OSD5);
      wr(A_FID, 16'h0105);
      settle(1'b1);
      chk(rgb, FRM);
      wr(A_FVB, 16'h0000);
      settle(1'b1);
      chk(rgb, OSD5);
      wr(A_FVB, 16'h0001);
      wr(A_FHB, 16'h0000);
      settle(1'b1);
      chk(rgb, OSD5);
   endtask

   // Colour differences judged by the order of the three outputs
   task automatic t_matrix;
      wr(A_MEXT, 16'h0000);
      settle(1'b1);
      chk({23'h0, rgb.r == rgb.b && rgb.g == rgb.b}, 24'h1);
      fc = 8'hc0;
      settle(1'b1);
      chk({23'h0, rgb.b > rgb.r && rgb.g < rgb.r}, 24'h1);
      wr(A_CIF, 16'h0018);
      settle(1'b1);
      chk({23'h0, rgb.r > rgb.b && rgb.g < rgb.b}, 24'h1);
      fc = 8'h80;
      wr(A_CIF, 16'h0000);
      settle(1'b1);
      chk({23'h0, rgb.r > rgb.b && rgb.g > rgb.r}, 24'h1);
      wr(A_CIF, {8'h00, CIF_RST});
      fc = 8'hc0;
      wr(A_SB1, 16'h0000);
      wr(A_SG1, 16'h0000);
      wr(A_MSIDE, 16'h00ff);
      settle(1'b1);
      chk({23'h0, rgb.r == rgb.b && rgb.g == rgb.b}, 24'h1);
      wr(A_MSIDE, 16'h0000);
      settle(1'b1);
      chk({23'h0, rgb.b > rgb.r}, 24'h1);
   endtask

   // Zero video setting gives no modulation; a luma step is clipped to the limit
   task automatic t_velmod;
      logic signed [7:0] pk;
      wr(A_SVL, 16'h003f);
      wr(A_SVD, 16'h0005);
      wr(A_SVV, 16'h0000);
      settle(1'b1);
      chk({16'h0000, vm}, 24'h000000);
      wr(A_SVV, 16'h007f);
      pk = 8'sh00;
      luma = 8'hff;
      repeat (40) begin
         tick;
         if (vm > pk) begin
            pk = vm;
         end
      end
      chk({16'h0000, pk}, 24'h00003f);
      luma = 8'h80;
      settle(1'b0);
   endtask

   // Reset, then scenarios in turn
   initial begin
      rst = 1'b1;
      reg_wr = '0;
      reg_raddr = 8'h00;
      luma = 8'h80;
      fc = 8'h80;
      sc = 8'h80;
      prio = 3'h0;
      idx = 4'h0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (20) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_format;
      t_table;
      t_frame;
      t_matrix;
      t_velmod;
      complete_run;
   end
endmodule
